//--- design/tmrps_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef TMRPS_REGS_SVH
`define TMRPS_REGS_SVH

// ============================================================
// Register indices (byte address = index * 4)
`define TMRPS_IDX_TIMER_COUNT 4'h1
`define TMRPS_IDX_CMP_CTRL 4'h7
`define TMRPS_IDX_CONFIG 4'h8
`define TMRPS_IDX_PIN_DIR 4'h9
`define TMRPS_IDX_WDT_CLEAR 4'hA
`define TMRPS_IDX_STATUS 4'hB

// ============================================================
// Reset values
`define TMRPS_RST_CONFIG 8'hFF
`define TMRPS_RST_CMP_CTRL 8'hFF
`define TMRPS_RST_PIN_DIR 4'hF
`define TMRPS_RST_TIMER 8'h00

// ============================================================
// Field positions
`define TMRPS_CFG_RATIO_LSB 0
`define TMRPS_CFG_ASSIGN 3
`define TMRPS_CFG_EDGE 4
`define TMRPS_CFG_SRC 5
`define TMRPS_CMP_RESULT 7
`define TMRPS_CMP_OUT_DIS 6
`define TMRPS_CMP_COUNT_SEL 4
`define TMRPS_CMP_ON 3
`define TMRPS_COUNT_PIN 2

// ============================================================
// Timing counts, in instruction cycles
`define TMRPS_INHIBIT_CYCLES 2'd2

`endif

//--- design/tmrps_pkg.sv
// Types shared by the timer and prescaler block
package tmrps_pkg;

  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    TMRPS_Q1,
    TMRPS_Q2,
    TMRPS_Q3,
    TMRPS_Q4
  } tmrps_qphase_t;

  // Source that feeds the prescaler input
  typedef enum logic [1:0] {
    TMRPS_SRC_INSTR,
    TMRPS_SRC_PIN,
    TMRPS_SRC_CMP
  } tmrps_src_t;

endpackage

//--- design/tmrps_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module tmrps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // tmrps_sync

//--- design/tmrps_top.sv
// Timer/counter with shared prescaler, external count sync and APB slave
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "tmrps_regs.svh"

// Functional notes
// - Sample prescaler output in Q2 and Q4
// - No prescaling: input passes straight to output
// - Prescaler divides input, symmetrical output
// - Timer increments after synchronised output seen
// - One counter: timer prescaler or watchdog postscaler
// - Assign bit and ratio field set division
// - Timer write clears prescaler when timer-assigned
// - Watchdog clear zeroes prescaler when watchdog-assigned
// - Prescaler never readable nor writable
// - Reset forces prescaler to zero
// - Timer count 8 bits, index one, kept; reset here loads zero
// - Clock source select overrides count pin direction
// - Assign bit clear gives prescaler to timer
// - Timer mode: increment per cycle, write inhibits two
// - Edge select: clear rising, set falling
module tmrps_top
  import tmrps_pkg::*;
#(
  parameter int PS_WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_input,
  input wire logic comparator_result,
  input wire logic wdt_tick,
  output logic wdt_postscaled_tick,
  output logic wdt_clear_pulse,
  output logic [3:0] pin_dir_effective,
  output logic [7:0] timer_value
);

  // ==========================================================
  // Helper functions
  function automatic logic ratio_bit(input logic [PS_WIDTH-1:0] cnt,
                                     input logic [2:0] ratio);
    ratio_bit = cnt[ratio];
  endfunction

  function automatic logic [PS_WIDTH-1:0] ratio_mask(input logic [2:0] r);
    ratio_mask = PS_WIDTH'((1 << r) - 1);
  endfunction

  function automatic logic idx_hit(input logic [7:0] a, input logic [3:0] i);
    idx_hit = (a[5:2] == i) && (a[7:6] == 2'h0);
  endfunction

  // ==========================================================
  // Input synchronisers
  logic pin_s;
  logic cmp_s;

  tmrps_sync #(.WIDTH(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({ext_count_input, comparator_result}),
    .sync_out({pin_s, cmp_s})
  );

  // ==========================================================
  // APB slave
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] cfg_q, cfg_d;
  logic [6:0] cmpc_q, cmpc_d;
  logic [3:0] pdir_q, pdir_d;
  logic [7:0] tmr_q, tmr_d;
  logic [PS_WIDTH-1:0] ps_q, ps_d;
  logic [1:0] inh_q, inh_d;
  tmrps_qphase_t qph_q, qph_d;
  logic src_prev_q, src_prev_d;
  logic samp_q, samp_d;
  logic wdt_out_q, wdt_out_d;
  logic wclr_q, wclr_d;
  logic [3:0] pdir_eff_q, pdir_eff_d;

  logic acc_fire;
  logic wr_fire;
  logic mapped;
  logic wr_timer;
  logic wr_wdt_clr;

  assign acc_fire = psel && penable && pready_q;
  assign wr_fire = acc_fire && pwrite;
  assign wr_timer = wr_fire && idx_hit(paddr, `TMRPS_IDX_TIMER_COUNT);
  assign wr_wdt_clr = wr_fire && idx_hit(paddr, `TMRPS_IDX_WDT_CLEAR);
  assign mapped = idx_hit(paddr, `TMRPS_IDX_TIMER_COUNT) ||
                  idx_hit(paddr, `TMRPS_IDX_CMP_CTRL) ||
                  idx_hit(paddr, `TMRPS_IDX_CONFIG) ||
                  idx_hit(paddr, `TMRPS_IDX_PIN_DIR) ||
                  idx_hit(paddr, `TMRPS_IDX_WDT_CLEAR) ||
                  idx_hit(paddr, `TMRPS_IDX_STATUS);

  always_comb begin
    pready_d = psel && penable && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (pready_d) begin
      pslverr_d = !mapped;
      if (!pwrite) begin
        // Config, pin direction and watchdog clear read as zero
        if (idx_hit(paddr, `TMRPS_IDX_TIMER_COUNT)) begin
          prdata_d = {24'h00_0000, tmr_q};
        end else if (idx_hit(paddr, `TMRPS_IDX_CMP_CTRL)) begin
          prdata_d = {24'h00_0000, cmp_s, cmpc_q};
        end else if (idx_hit(paddr, `TMRPS_IDX_STATUS)) begin
          prdata_d = {24'h00_0000, 1'b0, cfg_q[`TMRPS_CFG_ASSIGN],
                      inh_q, samp_q, src_prev_q, qph_q};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================
  // Configuration registers
  always_comb begin
    cfg_d = cfg_q;
    cmpc_d = cmpc_q;
    pdir_d = pdir_q;
    if (wr_fire && idx_hit(paddr, `TMRPS_IDX_CONFIG)) begin
      cfg_d = pwdata[7:0];
    end
    if (wr_fire && idx_hit(paddr, `TMRPS_IDX_CMP_CTRL)) begin
      cmpc_d = pwdata[6:0];
    end
    if (wr_fire && idx_hit(paddr, `TMRPS_IDX_PIN_DIR)) begin
      pdir_d = pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `TMRPS_RST_CONFIG;
      cmpc_q <= 7'(`TMRPS_RST_CMP_CTRL);
      pdir_q <= `TMRPS_RST_PIN_DIR;
    end else begin
      cfg_q <= cfg_d;
      cmpc_q <= cmpc_d;
      pdir_q <= pdir_d;
    end
  end

  // ==========================================================
  // Source selection
  logic use_counter;
  logic to_wdt;
  logic [2:0] ratio;
  tmrps_src_t src_sel;
  logic src_level;
  logic ps_out;
  logic src_rise;

  assign use_counter = cfg_q[`TMRPS_CFG_SRC];
  assign to_wdt = cfg_q[`TMRPS_CFG_ASSIGN];
  assign ratio = cfg_q[`TMRPS_CFG_RATIO_LSB +: 3];

  always_comb begin
    if (!use_counter) begin
      src_sel = TMRPS_SRC_INSTR;
    end else if (cmpc_q[`TMRPS_CMP_ON] &&
                 !(cmpc_q[`TMRPS_CMP_COUNT_SEL] &&
                   cmpc_q[`TMRPS_CMP_OUT_DIS])) begin
      src_sel = TMRPS_SRC_CMP;
    end else begin
      src_sel = TMRPS_SRC_PIN;
    end
  end

  always_comb begin
    case (src_sel)
      TMRPS_SRC_INSTR: src_level = (qph_q == TMRPS_Q3) ||
                                   (qph_q == TMRPS_Q4);
      // Falling edge selected: invert so rising edges are counted
      TMRPS_SRC_PIN: src_level = pin_s ^ cfg_q[`TMRPS_CFG_EDGE];
      TMRPS_SRC_CMP: src_level = cmp_s ^ cfg_q[`TMRPS_CFG_EDGE];
      default: src_level = 1'b0;
    endcase
  end

  assign src_rise = src_level && !src_prev_q;
  // Prescaled output is a counter bit, hence symmetrical
  assign ps_out = to_wdt ? src_level : ratio_bit(ps_q, ratio);

  // ==========================================================
  // Prescaler, phase, sampling and timer
  always_comb begin
    qph_d = qph_q;
    case (qph_q)
      TMRPS_Q1: qph_d = TMRPS_Q2;
      TMRPS_Q2: qph_d = TMRPS_Q3;
      TMRPS_Q3: qph_d = TMRPS_Q4;
      TMRPS_Q4: qph_d = TMRPS_Q1;
      default: qph_d = TMRPS_Q1;
    endcase
  end

  always_comb begin
    src_prev_d = src_level;
    ps_d = ps_q;
    wdt_out_d = 1'b0;
    wclr_d = wr_wdt_clr;
    if (to_wdt) begin
      if (wdt_tick) begin
        wdt_out_d = ((ps_q & ratio_mask(ratio)) == ratio_mask(ratio));
        ps_d = ps_q + PS_WIDTH'(1);
      end
    end else if (src_rise) begin
      ps_d = ps_q + PS_WIDTH'(1);
    end
    if (wr_timer && !to_wdt) begin
      ps_d = '0;
    end
    if (wr_wdt_clr && to_wdt) begin
      ps_d = '0;
    end
  end

  always_comb begin
    samp_d = samp_q;
    if (qph_q == TMRPS_Q2 || qph_q == TMRPS_Q4) begin
      samp_d = ps_out;
    end
    tmr_d = tmr_q;
    inh_d = inh_q;
    if (qph_q == TMRPS_Q4 && inh_q != 2'd0) begin
      inh_d = inh_q - 2'd1;
    end
    if (wr_timer) begin
      tmr_d = pwdata[7:0];
      inh_d = `TMRPS_INHIBIT_CYCLES;
    end else if (samp_d && !samp_q && inh_q == 2'd0) begin
      tmr_d = tmr_q + 8'h01;
    end
  end

  always_comb begin
    pdir_eff_d = pdir_q;
    if (use_counter) begin
      pdir_eff_d[`TMRPS_COUNT_PIN] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qph_q <= TMRPS_Q1;
      // Reset config counts falling edges of an idle-low pin: level is high
      src_prev_q <= 1'b1;
      ps_q <= '0;
      samp_q <= 1'b1;
      tmr_q <= `TMRPS_RST_TIMER;
      inh_q <= 2'd0;
      wdt_out_q <= 1'b0;
      wclr_q <= 1'b0;
      pdir_eff_q <= `TMRPS_RST_PIN_DIR;
    end else begin
      qph_q <= qph_d;
      src_prev_q <= src_prev_d;
      ps_q <= ps_d;
      samp_q <= samp_d;
      tmr_q <= tmr_d;
      inh_q <= inh_d;
      wdt_out_q <= wdt_out_d;
      wclr_q <= wclr_d;
      pdir_eff_q <= pdir_eff_d;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wdt_postscaled_tick = wdt_out_q;
  assign wdt_clear_pulse = wclr_q;
  assign pin_dir_effective = pdir_eff_q;
  assign timer_value = tmr_q;

endmodule // tmrps_top

//--- testbench/tmrps_assertions.sv
// Checker for the timer and prescaler block
`timescale 1ns/1ns
module tmrps_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_count_input,
  input wire logic comparator_result,
  input wire logic wdt_tick,
  input wire logic wdt_postscaled_tick,
  input wire logic wdt_clear_pulse,
  input wire logic [3:0] pin_dir_effective,
  input wire logic [7:0] timer_value
);
  // ====================
  // Shadow of the configuration register
  logic xfer;
  logic tw;
  logic [7:0] cfg_q;
  assign xfer = psel && penable && pready;
  assign tw = xfer && pwrite && paddr == 8'h04;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cfg_q <= 8'hFF;
    else if (xfer && pwrite && paddr == 8'h20) cfg_q <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_clear_pulse: assert property (
    xfer && pwrite && paddr == 8'h28 |=> wdt_clear_pulse)
    else $error("no clear pulse after clear write");
  a_clear_cause: assert property (
    wdt_clear_pulse |-> $past(xfer && pwrite && paddr == 8'h28))
    else $error("clear pulse without clear write");
  a_timer_load: assert property (
    tw |=> timer_value == $past(pwdata[7:0]))
    else $error("timer count not loaded");
  a_write_hold: assert property (
    tw |-> ##3 $stable(timer_value) [*2])
    else $error("timer moved during write inhibit");
  a_count_step: assert property (
    $changed(timer_value) |-> $past(tw) || $past(tw, 2) ||
      timer_value == 8'($past(timer_value) + 8'h01))
    else $error("timer changed by other than one");
  a_dir_force: assert property (
    cfg_q[5] && $past(cfg_q[5]) |-> pin_dir_effective[2])
    else $error("count pin direction not forced");
  a_wdt_every: assert property (
    cfg_q[3] && cfg_q[2:0] == 3'h0 && wdt_tick |=> wdt_postscaled_tick)
    else $error("undivided watchdog tick lost");
  a_wo_read: assert property (
    xfer && !pwrite && paddr inside {8'h20, 8'h24, 8'h28} |-> prdata == 0)
    else $error("write-only register read nonzero");
  a_bad_addr: assert property (xfer && paddr == 8'h30 |-> pslverr)
    else $error("unmapped address not refused");
endmodule // tmrps_assertions

bind tmrps_top tmrps_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_count_input(ext_count_input),
  .comparator_result(comparator_result), .wdt_tick(wdt_tick),
  .wdt_postscaled_tick(wdt_postscaled_tick),
  .wdt_clear_pulse(wdt_clear_pulse),
  .pin_dir_effective(pin_dir_effective), .timer_value(timer_value));

//--- testbench/tmrps_src_model.sv
// External count source: count pin and comparator output
`timescale 1ns/1ns
module tmrps_src_model (
  input wire logic pclk,
  output logic pin,
  output logic cmp
);
  initial begin
    pin = 1'b0;
    cmp = 1'b0;
  end
  // ====================
  // Line drivers, changed just after a clock edge
  task automatic level(input bit on_cmp, input bit v);
    @(posedge pclk);
    if (on_cmp) cmp <= v;
    else pin <= v;
  endtask
  // Half period of at least two cycles keeps sampling safe
  task automatic pulses(input int n, input int half, input bit on_cmp);
    repeat (n) begin
      level(on_cmp, 1'b1);
      repeat (half) @(posedge pclk);
      level(on_cmp, 1'b0);
      repeat (half) @(posedge pclk);
    end
  endtask
endmodule // tmrps_src_model

//--- testbench/tmrps_top_tb.sv
// Testbench for the timer and prescaler block
`timescale 1ns/1ns
module tmrps_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic pin, cmp, wdt_tick, wdt_postscaled_tick, wdt_clear_pulse;
  logic [7:0] paddr, timer_value;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pin_dir_effective;
  int err_total, comparisons, cyc, post_cnt, n, b;
  tmrps_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_input(pin),
    .comparator_result(cmp), .wdt_tick(wdt_tick),
    .wdt_postscaled_tick(wdt_postscaled_tick),
    .wdt_clear_pulse(wdt_clear_pulse),
    .pin_dir_effective(pin_dir_effective), .timer_value(timer_value));
  tmrps_src_model u_src (.pclk(pclk), .pin(pin), .cmp(cmp));
  // ====================
  // Clock, timeout and watchdog tick counter
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (wdt_postscaled_tick === 1'b1) post_cnt++;
    if (cyc > 60000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic gap(output int k);
    logic [7:0] v;
    v = timer_value;
    k = 0;
    while (timer_value === v && k < 3000) begin
      @(posedge pclk);
      k++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge pclk);
      wdt_tick <= 1'b1;
      @(posedge pclk);
      wdt_tick <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  // ====================
  // Main sequence
  initial begin
    {psel, penable, pwrite, wdt_tick, presetn} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pin_dir_effective, 4'hF);
    apb(0, 8'h2C, 0); chk(rd & 32'h40, 32'h40);
    apb(0, 8'h20, 0); chk(rd, 0);
    apb(0, 8'h30, 0); chk(err, 1);
    apb(0, 8'h1C, 0); chk(rd, 32'h7F);
    apb(1, 8'h20, 8'h08); apb(1, 8'h04, 8'hFE);
    // Let the loaded value show before timing the count
    @(posedge pclk);
    gap(n); chk(timer_value, 8'hFF);
    gap(n); chk(timer_value, 8'h00);
    chk(n, 4);
    apb(1, 8'h28, 0);
    for (int r = 0; r < 8; r++) begin
      apb(1, 8'h20, r);
      gap(n); gap(n); chk(n, 8 << r);
    end
    apb(1, 8'h28, 0); apb(1, 8'h04, 0);
    for (int e = 0; e < 2; e++) begin
      apb(1, 8'h20, {26'h0, 1'b1, e[0], 4'h8}); apb(1, 8'h04, 0);
      repeat (12) @(posedge pclk);
      u_src.level(0, 1); repeat (10) @(posedge pclk);
      chk(timer_value, e ? 0 : 1);
      u_src.level(0, 0); repeat (10) @(posedge pclk);
      chk(timer_value, 1);
    end
    apb(1, 8'h24, 0); repeat (2) @(posedge pclk);
    chk(pin_dir_effective, 4'h4);
    apb(1, 8'h28, 0); apb(1, 8'h20, 8'h20); apb(1, 8'h04, 0);
    repeat (12) @(posedge pclk);
    u_src.pulses(8, 3, 0); repeat (10) @(posedge pclk);
    chk(timer_value, 4);
    apb(1, 8'h20, 8'h21); apb(1, 8'h04, 8'h10);
    repeat (12) @(posedge pclk); u_src.pulses(1, 3, 0);
    apb(1, 8'h04, 8'h20); repeat (12) @(posedge pclk);
    u_src.pulses(1, 3, 0); repeat (10) @(posedge pclk);
    chk(timer_value, 8'h20);
    u_src.pulses(1, 3, 0); repeat (10) @(posedge pclk);
    chk(timer_value, 8'h21);
    apb(0, 8'h04, 0); chk(rd, 32'h21);
    apb(1, 8'h28, 0); apb(1, 8'h04, 0); apb(1, 8'h20, 8'h0F);
    apb(1, 8'h28, 0); apb(1, 8'h20, 8'h28);
    apb(1, 8'h1C, 8'h08); apb(1, 8'h04, 0);
    repeat (12) @(posedge pclk);
    u_src.pulses(3, 2, 1); repeat (10) @(posedge pclk);
    chk(timer_value, 3);
    apb(1, 8'h20, 8'h0A); repeat (2) @(posedge pclk);
    chk(pin_dir_effective, 4'h0);
    apb(1, 8'h28, 0); tick(2); apb(1, 8'h28, 0);
    b = post_cnt; tick(2); chk(32'(post_cnt - b), 0);
    tick(2); chk(32'(post_cnt - b), 1);
    apb(1, 8'h20, 8'h08); b = post_cnt;
    tick(1); chk(32'(post_cnt - b), 1);
    finish_test();
  end
endmodule // tmrps_top_tb
